// file: por_partner.sv
module por_partner (
	input wire logic rst_pin_oe,
	input wire logic sup_on,
	input wire logic hold_low,
	output logic supply_ok,
	output logic rst_pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// comparator and pulled-up reset pin
	assign supply_ok = sup_on;
	// either party may pull low; pull-up otherwise, so no stale value
	assign rst_pin_in = !(rst_pin_oe || hold_low);
endmodule : por_partner

// file: por_pkg.sv
package por_pkg;
	// ==========================================
	// reset-source register layout
	localparam int RSRC_W = 8;
	localparam int POR_FLAG_BIT = 1;
	localparam logic [7:0] RSRC_RESET = 8'h00;
	// ==========================================
	// program start address, same for every reset
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	// ==========================================
	// release delay after supply settles
	localparam int CLK_PERIOD_NS = 10;
	localparam int RELEASE_DELAY_NS = 10000;
	localparam int RELEASE_CYCLES = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	typedef enum logic [2:0] {
		ST_HOLD = 3'h1,
		ST_DELAY = 3'h2,
		ST_RUN = 3'h4
	} por_state_t;

	typedef struct packed {
		logic core_reset;
		logic rst_pin_out;
		logic rst_pin_oe;
		logic vdd_monitor_en;
		logic [15:0] start_addr;
		logic [RSRC_W-1:0] reset_source_register;
	} por_out_t;

	typedef struct packed {
		por_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [1:0] vok_sync;
		logic [1:0] pin_sync;
		logic pin_prev;
		logic por_pending;
		logic [6:0] other_src;
		por_out_t out;
	} por_regs_t;
endpackage : por_pkg

// file: power_on_reset_control.sv
// Functional notes
// R1: hold device in reset and drive reset pin low while supply below threshold.
// R2: set power-on flag, bit 1 of reset source, when leaving power-on reset.
// R3: other reset-cause flags are undefined while power-on flag is set.
// R4: any other reset cause clears the power-on flag.
// R5: every reset starts execution at address 0x0000.
// R6: data memory is not initialised by a power-on reset.
// R7: power-on reset completion leaves the supply monitor enabled.
// R8: release from reset is delayed after supply crosses threshold.
// R9: outside party should not hold reset pin low over one second on old parts.
// R10: delay counter starts on supply good and restarts if supply drops.
// R11: power-on flag stays readable until another reset cause clears it.
module power_on_reset_control #(
	parameter int RELEASE_COUNT = por_pkg::RELEASE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic rst_pin_in,
	input wire logic [6:0] other_reset_req,
	output por_pkg::por_out_t status
);
	import por_pkg::*;

	por_regs_t r_q;
	por_regs_t r_d;

	// ==========================================
	// helpers
	// the pin is active low, so a fall of the synced level is a pin reset
	function automatic logic pin_fell(input logic prev, input logic level);
		return prev && !level;
	endfunction : pin_fell

	// shared by the delay branch and its checks so both agree on the end point
	function automatic logic release_due(input logic [CNT_W-1:0] count);
		return count >= CNT_W'(RELEASE_COUNT - 1);
	endfunction : release_due

	// ==========================================
	// next state
	always_comb begin
		r_d = r_q;
		r_d.vok_sync = {r_q.vok_sync[0], supply_ok};
		r_d.pin_sync = {r_q.pin_sync[0], rst_pin_in};
		r_d.pin_prev = r_q.pin_sync[1];
		case (r_q.st)
			ST_HOLD: begin
				r_d.cnt = '0;
				if (r_q.vok_sync[1]) begin
					r_d.st = ST_DELAY; // R10
				end
			end
			ST_DELAY: begin
				if (!r_q.vok_sync[1]) begin
					r_d.st = ST_HOLD; // R10
					r_d.cnt = '0;
				end else if (release_due(r_q.cnt)) begin
					r_d.st = ST_RUN; // R8
				end else begin
					r_d.cnt = r_q.cnt + 1'b1;
				end
			end
			ST_RUN: begin
				if (!r_q.vok_sync[1]) begin
					r_d.st = ST_HOLD;
					r_d.por_pending = 1'b1;
				end
			end
			default: r_d.st = ST_HOLD;
		endcase
		// reset outputs follow the next state so they come from flops
		r_d.out.core_reset = (r_d.st != ST_RUN); // R1
		r_d.out.rst_pin_oe = (r_d.st != ST_RUN); // R1
		r_d.out.rst_pin_out = 1'b0;
		r_d.out.start_addr = RESET_VECTOR; // R5
		// memory is left alone: no clear logic exists on purpose // R6
		if (r_q.st == ST_DELAY && r_d.st == ST_RUN && r_q.por_pending) begin
			r_d.out.reset_source_register[POR_FLAG_BIT] = 1'b1; // R2
			r_d.out.vdd_monitor_en = 1'b1; // R7
			r_d.por_pending = 1'b0;
		end
		// a pin pull-down or internal request while running is a non-power reset
		// the pin cause comes from the fall, not the level, which is still low just after release
		if (r_q.st == ST_RUN && (pin_fell(r_q.pin_prev, r_q.pin_sync[1]) || |other_reset_req)) begin
			r_d.out.reset_source_register[POR_FLAG_BIT] = 1'b0; // R4
			r_d.other_src = other_reset_req | {6'h00, pin_fell(r_q.pin_prev, r_q.pin_sync[1])};
		end
		// other flags are only meaningful when the power-on flag is clear
		r_d.out.reset_source_register[RSRC_W-1:2] = r_d.other_src[6:1]; // R3
		r_d.out.reset_source_register[0] = r_d.other_src[0];
	end

	// ==========================================
	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_q.st <= ST_HOLD;
			r_q.cnt <= '0;
			r_q.vok_sync <= 2'h0;
			r_q.pin_sync <= 2'h3;
			r_q.pin_prev <= 1'b1;
			r_q.por_pending <= 1'b1;
			r_q.other_src <= 7'h00;
			r_q.out.core_reset <= 1'b1;
			r_q.out.rst_pin_oe <= 1'b1;
			r_q.out.rst_pin_out <= 1'b0;
			r_q.out.vdd_monitor_en <= 1'b0;
			r_q.out.start_addr <= RESET_VECTOR;
			r_q.out.reset_source_register <= RSRC_RESET;
		end else begin
			r_q <= r_d; // R11
		end
	end

	assign status = r_q.out;

	// ==========================================
	// checks: hold, pin drive and start vector
	a_pin_hold: assert property (@(posedge ref_clk) disable iff (rst) // R1
		(r_q.st != ST_RUN)
		|-> (status.rst_pin_oe && !status.rst_pin_out && status.core_reset))
		else $error("reset pin not driven low while held");

	a_pin_level: assert property (@(posedge ref_clk) disable iff (rst) // R1
		status.rst_pin_out == 1'b0)
		else $error("reset pin drive level not low");

	a_run_release: assert property (@(posedge ref_clk) disable iff (rst) // R1 R8
		(r_q.st == ST_RUN)
		|-> (!status.core_reset && !status.rst_pin_oe))
		else $error("reset not released while running");

	a_drop_hold: assert property (@(posedge ref_clk) disable iff (rst) // R1
		(r_q.st == ST_RUN && !r_q.vok_sync[1])
		|=> (r_q.st == ST_HOLD && status.core_reset))
		else $error("supply drop did not re-enter reset");

	a_start_vector: assert property (@(posedge ref_clk) disable iff (rst) // R5
		status.start_addr == 16'h0000)
		else $error("start address wrong");

	// ==========================================
	// checks: release delay
	a_delay_min: assert property (@(posedge ref_clk) disable iff (rst) // R8
		$rose(r_q.st == ST_DELAY) |-> (r_q.st == ST_DELAY)[*3])
		else $error("release not delayed");

	a_hold_stay: assert property (@(posedge ref_clk) disable iff (rst) // R8
		(r_q.st == ST_HOLD)
		|=> (r_q.st != ST_RUN))
		else $error("release straight from hold");

	a_release_count: assert property (@(posedge ref_clk) disable iff (rst) // R8 R10
		$rose(r_q.st == ST_RUN)
		|-> ($past(r_q.cnt) == CNT_W'(RELEASE_COUNT - 1)))
		else $error("release before delay count ended");

	a_delay_reach: assert property (@(posedge ref_clk) disable iff (rst) // R8
		(r_q.st == ST_DELAY && r_q.vok_sync[1] && release_due(r_q.cnt))
		|=> (r_q.st == ST_RUN))
		else $error("release missed at end of delay");

	a_delay_start: assert property (@(posedge ref_clk) disable iff (rst) // R10
		$rose(r_q.st == ST_DELAY)
		|-> (r_q.cnt == '0))
		else $error("delay count not started from zero");

	a_delay_step: assert property (@(posedge ref_clk) disable iff (rst) // R10
		(r_q.st == ST_DELAY && r_q.vok_sync[1] && !release_due(r_q.cnt))
		|=> (r_q.st == ST_DELAY && r_q.cnt == $past(r_q.cnt) + 1'b1))
		else $error("delay count did not advance");

	a_delay_restart: assert property (@(posedge ref_clk) disable iff (rst) // R10
		(r_q.st == ST_DELAY && !r_q.vok_sync[1])
		|=> (r_q.st == ST_HOLD && r_q.cnt == 0))
		else $error("delay not restarted");

	a_state_onehot: assert property (@(posedge ref_clk) disable iff (rst) // R10
		$onehot(r_q.st))
		else $error("sequencer state not one-hot");

	// ==========================================
	// checks: reset-source flags
	a_flag_set: assert property (@(posedge ref_clk) disable iff (rst) // R2
		($rose(r_q.st == ST_RUN) && $past(r_q.por_pending, 2))
		|-> status.reset_source_register[POR_FLAG_BIT])
		else $error("power-on flag not set at release");

	a_flag_rise: assert property (@(posedge ref_clk) disable iff (rst) // R2 R4
		$rose(status.reset_source_register[POR_FLAG_BIT])
		|-> $rose(r_q.st == ST_RUN))
		else $error("power-on flag set outside release");

	a_pending_rearm: assert property (@(posedge ref_clk) disable iff (rst) // R2
		(r_q.st == ST_RUN && !r_q.vok_sync[1])
		|=> r_q.por_pending)
		else $error("power-on not re-armed by supply drop");

	a_flag_clear: assert property (@(posedge ref_clk) disable iff (rst) // R4
		(r_q.st == ST_RUN && |other_reset_req)
		|=> !status.reset_source_register[POR_FLAG_BIT])
		else $error("power-on flag not cleared by other reset");

	a_pin_clear: assert property (@(posedge ref_clk) disable iff (rst) // R3 R4
		(r_q.st == ST_RUN && pin_fell(r_q.pin_prev, r_q.pin_sync[1]))
		|=> (!status.reset_source_register[POR_FLAG_BIT]
		&& status.reset_source_register[0]))
		else $error("pin reset not recorded");

	a_src_latch: assert property (@(posedge ref_clk) disable iff (rst) // R3
		(r_q.st == ST_RUN && |other_reset_req)
		|=> (status.reset_source_register[RSRC_W-1:2] == $past(other_reset_req[6:1])))
		else $error("other reset causes not latched");

	a_flag_keep: assert property (@(posedge ref_clk) disable iff (rst) // R11
		(r_q.st == ST_RUN && status.reset_source_register[POR_FLAG_BIT] && !(|other_reset_req)
		&& !pin_fell(r_q.pin_prev, r_q.pin_sync[1]))
		|=> status.reset_source_register[POR_FLAG_BIT])
		else $error("power-on flag lost");

	// ==========================================
	// checks: supply monitor
	a_mon_on: assert property (@(posedge ref_clk) disable iff (rst) // R7
		$fell(status.core_reset) && status.reset_source_register[POR_FLAG_BIT]
		|-> status.vdd_monitor_en)
		else $error("supply monitor not enabled");

	a_mon_sticky: assert property (@(posedge ref_clk) disable iff (rst) // R7
		status.vdd_monitor_en
		|=> status.vdd_monitor_en)
		else $error("supply monitor switched off");
endmodule : power_on_reset_control

// file: test_power_on_reset_control.sv
module test_power_on_reset_control;
	timeunit 1ns;
	timeprecision 1ns;
	import por_pkg::*;
	localparam int RC = 4;
	logic ref_clk = 0;
	logic rst = 1;
	logic sup_on = 0;
	logic supply_ok;
	logic rst_pin_in;
	logic [6:0] other_reset_req = '0;
	logic hold_low = 0;
	por_out_t status;
	int fail_count = 0;
	int checks = 0;
	int n;
	bit exp_flag;
	int exp_src;
	power_on_reset_control #(.RELEASE_COUNT(RC)) power_on_reset_control_inst (.ref_clk(ref_clk),
		.rst(rst), .supply_ok(supply_ok), .rst_pin_in(rst_pin_in),
		.other_reset_req(other_reset_req), .status(status));
	por_partner por_partner_inst (.rst_pin_oe(status.rst_pin_oe), .sup_on(sup_on),
		.hold_low(hold_low), .supply_ok(supply_ok), .rst_pin_in(rst_pin_in));
	initial forever #5 ref_clk = ~ref_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// bounded wait; n is cycles from the last supply rise
	task release_wait;
		n = 0;
		while (status.core_reset !== 1'b0 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : release_wait
	task chk_state(input logic in_rst);
		chk(status.core_reset, in_rst);
		chk(status.rst_pin_oe, in_rst);
		chk(status.rst_pin_out, 0);
		chk(status.reset_source_register[POR_FLAG_BIT], exp_flag);
		chk(status.start_addr, RESET_VECTOR);
	endtask : chk_state
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(1876));
		repeat (10) @(negedge ref_clk);
		rst = 0;
		exp_flag = 0;
		chk_state(1);
		chk(status.vdd_monitor_en, 0);
		chk(status.reset_source_register, 8'h00);
		sup_on = 1;
		repeat (RC) @(negedge ref_clk);
		sup_on = 0;
		repeat (3) @(negedge ref_clk);
		chk(status.core_reset, 1);
		sup_on = 1;
		release_wait();
		exp_flag = 1;
		chk(n, RC + 3);
		chk_state(0);
		chk(status.vdd_monitor_en, 1);
		$display("test power-up done");
		other_reset_req = 7'h01 << ($urandom % 7);
		exp_src = {other_reset_req[6:1], 1'b0, other_reset_req[0]};
		@(negedge ref_clk);
		other_reset_req = '0;
		repeat (4) @(negedge ref_clk);
		exp_flag = 0;
		chk_state(0);
		chk(status.reset_source_register, exp_src);
		$display("test other cause done");
		sup_on = 0;
		repeat (4) @(negedge ref_clk);
		chk(status.core_reset, 1);
		chk(status.rst_pin_oe, 1);
		sup_on = 1;
		release_wait();
		exp_flag = 1;
		chk_state(0);
		chk(n, RC + 3);
		chk(status.vdd_monitor_en, 1);
		$display("test brown-out done");
		repeat (3) @(negedge ref_clk);
		hold_low = 1;
		repeat (3) @(negedge ref_clk);
		hold_low = 0;
		repeat (2) @(negedge ref_clk);
		exp_flag = 0;
		chk_state(0);
		chk(status.reset_source_register, 8'h01);
		$display("test pin reset done");
		end_sim();
	end
	initial begin
		#20us;
		fail_count++;
		end_sim();
	end
endmodule : test_power_on_reset_control
